// file: include/lag_pkg.sv
// constants and types shared by the lpc locality access gate
package lag_pkg;
	// ---------------------------------------------------------------
	// lpc field codes
	// ---------------------------------------------------------------
	localparam logic [3:0] START_TPM = 4'h5;
	localparam logic [3:0] SYNC_OK = 4'h0;
	localparam logic [3:0] SYNC_LWAIT = 4'h6;
	localparam logic [3:0] TAR_IDLE = 4'hf;
	localparam logic [1:0] CTYPE_TPM = 2'h0;
	localparam int CTYPE_DIR_BIT = 1;
	localparam logic [1:0] ADDR_LAST = 2'h3;
	// ---------------------------------------------------------------
	// register map, locality in addr[15:12], offset in addr[11:0]
	// ---------------------------------------------------------------
	localparam logic [11:0] OFS_ACCESS = 12'h000;
	localparam logic [11:0] OFS_INT_ENABLE = 12'h008;
	localparam logic [11:0] OFS_IRQ_VECTOR = 12'h00c;
	localparam logic [11:0] OFS_INT_STATUS = 12'h010;
	localparam logic [11:0] OFS_INT_CAP = 12'h014;
	localparam logic [11:0] OFS_XFER_STATUS = 12'h018;
	localparam logic [11:0] OFS_DIGEST_FINISH = 12'h020;
	// shared fifo; in the digest locality this word is the payload
	localparam logic [11:0] OFS_SHARED_FIFO = 12'h024;
	localparam logic [11:0] OFS_DIGEST_BEGIN = 12'h028;
	localparam logic [3:0] CFG_PAGE = 4'hf;
	localparam logic [3:0] DIGEST_LOC = 4'h4;
	localparam logic [3:0] LAST_LOC = 4'h4;
	localparam int NUM_LOC = 5;
	// ---------------------------------------------------------------
	// fields and reset values
	// ---------------------------------------------------------------
	localparam int ACC_REQ_BIT = 1;
	localparam int ACC_ACTIVE_BIT = 5;
	localparam int ACC_VALID_BIT = 7;
	localparam int RESP_READY_BIT = 4;
	localparam logic [7:0] INT_ENABLE_RST = 8'h00;
	localparam logic [3:0] IRQ_VECTOR_RST = 4'h0;
	localparam logic [7:0] INT_STATUS_RST = 8'h00;
	localparam logic [7:0] INT_CAP_VALUE = 8'h0f;
	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLOCK_KHZ = 250000;
	localparam int IDLE_TIME_MS = 50;
	localparam int IDLE_CYCLES = IDLE_TIME_MS * CLOCK_KHZ;
	localparam int WAKE_CYCLES = 16;
	localparam int SIRQ_START_MIN = 4;
	localparam logic [4:0] SIRQ_LAST_SLOT = 5'h0f;
	localparam logic [1:0] SIRQ_LAST_PHASE = 2'h2;
	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef enum {REG_ACCESS, REG_INT_ENABLE, REG_IRQ_VECTOR,
		REG_INT_STATUS, REG_INT_CAP, REG_XFER_STATUS, REG_SHARED_FIFO,
		REG_CONFIG, REG_DIGEST_BEGIN, REG_DIGEST_PAYLOAD,
		REG_DIGEST_FINISH, REG_NONE} lag_reg_t;
	typedef enum {ST_IDLE, ST_CTYPE, ST_ADDR, ST_WDATA, ST_TAR1, ST_TAR2,
		ST_SYNC, ST_RDATA, ST_TARB} lag_state_t;
endpackage : lag_pkg

// file: include/lag_rule_if.sv
// decision signals between the cycle engine and the access matrix
`timescale 1ns/1ps
interface lag_rule_if;
	import lag_pkg::*;
	lag_reg_t sel;
	logic isWrite;
	logic ownActive;
	logic anyActive;
	logic dataAvail;
	logic allow;
	modport engine (output sel, isWrite, ownActive, anyActive, dataAvail,
		input allow);
	modport matrix (input sel, isWrite, ownActive, anyActive, dataAvail,
		output allow);
endinterface : lag_rule_if

// file: hdl/lag_access_matrix.sv
// per register service or abort decision
`timescale 1ns/1ps
module lag_access_matrix
(
	// decision
	lag_rule_if.matrix rule
);
	import lag_pkg::*;

	always_comb
	begin
		rule.allow = 1'b0;
		if (rule.ownActive)
		begin
			case (rule.sel)
				REG_ACCESS, REG_INT_ENABLE, REG_IRQ_VECTOR, REG_INT_STATUS,
				REG_XFER_STATUS, REG_CONFIG: rule.allow = 1'b1;
				REG_INT_CAP: rule.allow = !rule.isWrite;
				REG_SHARED_FIFO:
					rule.allow = rule.isWrite || rule.dataAvail;
				REG_DIGEST_BEGIN, REG_DIGEST_PAYLOAD, REG_DIGEST_FINISH:
					rule.allow = rule.isWrite;
				default: rule.allow = 1'b0;
			endcase
		end
		else
		begin
			case (rule.sel)
				REG_ACCESS: rule.allow = 1'b1;
				REG_INT_ENABLE, REG_IRQ_VECTOR, REG_INT_STATUS, REG_INT_CAP,
				REG_CONFIG: rule.allow = !rule.isWrite;
				REG_DIGEST_BEGIN:
					rule.allow = rule.isWrite && !rule.anyActive;
				default: rule.allow = 1'b0;
			endcase
		end
	end
endmodule : lag_access_matrix

// file: hdl/lag_access_gate.sv
// lpc target cycle engine with locality access gating and idle control
//
// Overview of operation
// - no power-down input, no clock-run handshake
// - sleeps by itself after each completed command
// - wakes on bus activity, sleeps 50 ms later
// - rejected cycle: no sync, nothing changes
// - rejected write data still reaches writeData, but regWrite never pulses
// - fifo read and write share one register
// - direction and locality state pick service
// - active locality access set, status write clears
// - inactive localities: access register, reads of enable, vector, status, cap, config only
// - digest begin with none active grants locality four
// - digest finish releases locality four
// - fifo read aborts without response ready
// - four-bit shared bus, both sides turn
// - frame low starts cycle, ends broken one
// - reset clears all state unconditionally and starts in low power
// - only tpm read and write cycles answered
// - never sync error, long waits then ok
// - interrupts sent over serial irq line
`timescale 1ns/1ps
module lag_access_gate
	import lag_pkg::*;
#(
	parameter int IDLE_COUNT = lag_pkg::IDLE_CYCLES,
	parameter int WAKE_COUNT = lag_pkg::WAKE_CYCLES
)
(
	// clock and reset
	input wire logic clock,
	input wire logic reset,
	// lpc bus
	input wire logic [3:0] ladIn,
	output logic [3:0] ladOut,
	output logic ladOe,
	input wire logic lframeN,
	// serial interrupt line
	input wire logic serirqIn,
	output logic serirqOut,
	output logic serirqOe,
	// command engine side
	input wire logic [7:0] xferStatus,
	input wire logic [7:0] fifoReadData,
	input wire logic [7:0] cfgReadData,
	input wire logic [7:0] intEvents,
	input wire logic cmdDone,
	output logic [15:0] cycleAddr,
	output logic [7:0] writeData,
	output logic regWrite,
	output logic fifoPop,
	// state
	output logic [4:0] activeLocality,
	output logic lowPower,
	output logic irqPending
);
	import lag_pkg::*;

	localparam int IW = $clog2(IDLE_COUNT + 1);
	localparam int WW = $clog2(WAKE_COUNT + 1);

	lag_state_t state, next_state;
	logic isWrite, next_isWrite;
	logic [1:0] nib, next_nib;
	logic [15:0] next_cycleAddr;
	logic [7:0] next_writeData, rdata, next_rdata, readValue;
	logic [3:0] next_ladOut;
	logic next_ladOe, next_regWrite, next_fifoPop, commit;
	logic [4:0] next_activeLocality;
	logic [7:0] intEnable, next_intEnable, intStatus, next_intStatus;
	logic [3:0] irqVector, next_irqVector;
	logic next_irqPending, next_lowPower;
	logic [IW-1:0] idleCnt, next_idleCnt;
	logic [WW-1:0] wakeCnt, next_wakeCnt;
	logic [3:0] loc;
	logic [2:0] locIdx;
	logic [3:0] syncNib;
	lag_reg_t sel;
	lag_rule_if rule ();

	// ---------------------------------------------------------------
	// decode and access decision
	// ---------------------------------------------------------------
	function automatic lag_reg_t decodeReg(input logic [15:0] a);
		logic [11:0] w;
		w = {a[11:2], 2'b00};
		decodeReg = REG_NONE;
		if (a[15:12] > LAST_LOC)
			decodeReg = REG_NONE;
		else if (a[11:8] == CFG_PAGE)
			decodeReg = REG_CONFIG;
		else
		begin
			case (w)
				OFS_ACCESS: decodeReg = REG_ACCESS;
				OFS_INT_ENABLE: decodeReg = REG_INT_ENABLE;
				OFS_IRQ_VECTOR: decodeReg = REG_IRQ_VECTOR;
				OFS_INT_STATUS: decodeReg = REG_INT_STATUS;
				OFS_INT_CAP: decodeReg = REG_INT_CAP;
				OFS_XFER_STATUS: decodeReg = REG_XFER_STATUS;
				OFS_SHARED_FIFO: decodeReg = (a[15:12] == DIGEST_LOC) ?
					REG_DIGEST_PAYLOAD : REG_SHARED_FIFO;
				OFS_DIGEST_BEGIN: decodeReg = (a[15:12] == DIGEST_LOC) ?
					REG_DIGEST_BEGIN : REG_NONE;
				OFS_DIGEST_FINISH: decodeReg = (a[15:12] == DIGEST_LOC) ?
					REG_DIGEST_FINISH : REG_NONE;
				default: decodeReg = REG_NONE;
			endcase
		end
	endfunction : decodeReg

	assign loc = cycleAddr[15:12];
	assign locIdx = cycleAddr[14:12];
	assign sel = decodeReg(cycleAddr);
	assign rule.sel = sel;
	assign rule.isWrite = isWrite;
	assign rule.ownActive = (loc <= LAST_LOC) && activeLocality[locIdx];
	assign rule.anyActive = |activeLocality;
	assign rule.dataAvail = xferStatus[RESP_READY_BIT];
	// waking from low power is covered by long waits
	assign syncNib = (wakeCnt == '0) ? SYNC_OK : SYNC_LWAIT;

	lag_access_matrix matrix (.rule(rule));

	// ---------------------------------------------------------------
	// lpc cycle engine
	// ---------------------------------------------------------------
	always_comb
	begin
		next_state = state;
		next_isWrite = isWrite;
		next_nib = nib;
		next_cycleAddr = cycleAddr;
		next_writeData = writeData;
		next_rdata = rdata;
		next_ladOut = TAR_IDLE;
		next_ladOe = 1'b0;
		next_regWrite = 1'b0;
		next_fifoPop = 1'b0;
		commit = 1'b0;
		if (!lframeN)
			next_state = (ladIn == START_TPM) ? ST_CTYPE : ST_IDLE;
		else
		begin
			case (state)
				ST_IDLE: next_state = ST_IDLE;
				ST_CTYPE:
				begin
					next_state = ST_IDLE;
					if (ladIn[3:2] == CTYPE_TPM)
					begin
						next_isWrite = ladIn[CTYPE_DIR_BIT];
						next_nib = 2'h0;
						next_state = ST_ADDR;
					end
				end
				ST_ADDR:
				begin
					next_cycleAddr = {cycleAddr[11:0], ladIn};
					next_nib = nib + 2'h1;
					if (nib == ADDR_LAST)
					begin
						next_nib = 2'h0;
						next_state = isWrite ? ST_WDATA : ST_TAR1;
					end
				end
				ST_WDATA:
				begin
					next_nib = nib + 2'h1;
					if (nib == 2'h0)
						next_writeData = {writeData[7:4], ladIn};
					else
					begin
						next_writeData = {ladIn, writeData[3:0]};
						next_state = ST_TAR1;
					end
				end
				ST_TAR1: next_state = ST_TAR2;
				ST_TAR2, ST_SYNC:
				begin
					if (state == ST_SYNC && ladOut == SYNC_OK)
					begin
						next_ladOe = 1'b1;
						next_nib = 2'h0;
						next_ladOut = isWrite ? TAR_IDLE : rdata[3:0];
						next_state = isWrite ? ST_TARB : ST_RDATA;
					end
					// an aborted cycle never drives the bus
					else if (rule.allow)
					begin
						next_state = ST_SYNC;
						next_ladOe = 1'b1;
						next_ladOut = syncNib;
						if (syncNib == SYNC_OK)
						begin
							commit = 1'b1;
							next_rdata = readValue;
							next_regWrite = isWrite;
							next_fifoPop = !isWrite && sel == REG_SHARED_FIFO;
						end
					end
					else
						next_state = ST_IDLE;
				end
				ST_RDATA:
				begin
					next_ladOe = 1'b1;
					next_nib = nib + 2'h1;
					next_ladOut = (nib == 2'h0) ? rdata[7:4] : TAR_IDLE;
					next_state = (nib == 2'h0) ? ST_RDATA : ST_TARB;
				end
				ST_TARB: next_state = ST_IDLE;
				default: next_state = ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			state <= ST_IDLE;
			isWrite <= 1'b0;
			nib <= 2'h0;
			cycleAddr <= 16'h0000;
			writeData <= 8'h00;
			rdata <= 8'h00;
			ladOut <= TAR_IDLE;
			ladOe <= 1'b0;
			regWrite <= 1'b0;
			fifoPop <= 1'b0;
		end
		else
		begin
			state <= next_state;
			isWrite <= next_isWrite;
			nib <= next_nib;
			cycleAddr <= next_cycleAddr;
			writeData <= next_writeData;
			rdata <= next_rdata;
			ladOut <= next_ladOut;
			ladOe <= next_ladOe;
			regWrite <= next_regWrite;
			fifoPop <= next_fifoPop;
		end
	end

	// ---------------------------------------------------------------
	// locality and interrupt registers
	// ---------------------------------------------------------------
	always_comb
	begin
		next_activeLocality = activeLocality;
		next_intEnable = intEnable;
		next_irqVector = irqVector;
		next_intStatus = intStatus;
		if (commit && isWrite)
		begin
			case (sel)
				REG_ACCESS:
					if (writeData[ACC_ACTIVE_BIT])
						next_activeLocality[locIdx] = 1'b0;
					else if (writeData[ACC_REQ_BIT] && activeLocality == '0)
						next_activeLocality[locIdx] = 1'b1;
				REG_INT_ENABLE: next_intEnable = writeData;
				REG_IRQ_VECTOR: next_irqVector = writeData[3:0];
				REG_INT_STATUS:
					next_intStatus = intStatus & ~writeData;
				REG_DIGEST_BEGIN:
					next_activeLocality[DIGEST_LOC[2:0]] = 1'b1;
				REG_DIGEST_FINISH:
					next_activeLocality[DIGEST_LOC[2:0]] = 1'b0;
				default: next_activeLocality = activeLocality;
			endcase
		end
		// a new event wins over a clear in the same cycle
		next_intStatus = next_intStatus | intEvents;
		next_irqPending = |(intStatus & intEnable);
		case (sel)
			REG_ACCESS: readValue = {1'b1, 1'b0, rule.ownActive, 5'h00};
			REG_INT_ENABLE: readValue = intEnable;
			REG_IRQ_VECTOR: readValue = {4'h0, irqVector};
			REG_INT_STATUS: readValue = intStatus;
			REG_INT_CAP: readValue = INT_CAP_VALUE;
			REG_XFER_STATUS: readValue = xferStatus;
			REG_SHARED_FIFO: readValue = fifoReadData;
			REG_CONFIG: readValue = cfgReadData;
			default: readValue = 8'h00;
		endcase
	end

	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			activeLocality <= '0;
			intEnable <= INT_ENABLE_RST;
			irqVector <= IRQ_VECTOR_RST;
			intStatus <= INT_STATUS_RST;
			irqPending <= 1'b0;
		end
		else
		begin
			activeLocality <= next_activeLocality;
			intEnable <= next_intEnable;
			irqVector <= next_irqVector;
			intStatus <= next_intStatus;
			irqPending <= next_irqPending;
		end
	end

	// ---------------------------------------------------------------
	// idle control, no external power-down pins exist
	// ---------------------------------------------------------------
	always_comb
	begin
		next_lowPower = lowPower;
		next_idleCnt = idleCnt;
		next_wakeCnt = wakeCnt;
		if (wakeCnt != '0)
			next_wakeCnt = wakeCnt - 1'b1;
		if (!lframeN && lowPower)
		begin
			next_lowPower = 1'b0;
			next_wakeCnt = WW'(WAKE_COUNT);
			next_idleCnt = IW'(IDLE_COUNT);
		end
		else if (cmdDone)
			next_idleCnt = IW'(IDLE_COUNT);
		else if (!lowPower && idleCnt != '0)
		begin
			next_idleCnt = idleCnt - 1'b1;
			if (idleCnt == IW'(1))
				next_lowPower = 1'b1;
		end
	end

	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			lowPower <= 1'b1;
			idleCnt <= '0;
			wakeCnt <= '0;
		end
		else
		begin
			lowPower <= next_lowPower;
			idleCnt <= next_idleCnt;
			wakeCnt <= next_wakeCnt;
		end
	end

	// ---------------------------------------------------------------
	// serial irq slot driver, continuous mode only
	// ---------------------------------------------------------------
	logic inFrame, next_inFrame;
	logic [2:0] lowRun, next_lowRun;
	logic [4:0] slot, next_slot;
	logic [1:0] phase, next_phase;
	logic next_serirqOut, next_serirqOe;

	always_comb
	begin
		next_inFrame = inFrame;
		next_lowRun = 3'h0;
		next_slot = slot;
		next_phase = phase;
		next_serirqOut = 1'b1;
		next_serirqOe = 1'b0;
		if (!inFrame)
		begin
			if (!serirqIn)
				next_lowRun = (lowRun == 3'h7) ? lowRun : lowRun + 3'h1;
			else if (lowRun >= 3'(SIRQ_START_MIN))
			begin
				next_inFrame = 1'b1;
				next_slot = 5'h1f;
				next_phase = SIRQ_LAST_PHASE;
			end
		end
		else if (phase == SIRQ_LAST_PHASE)
		begin
			next_phase = 2'h0;
			next_slot = slot + 5'h1;
			next_inFrame = slot != SIRQ_LAST_SLOT;
		end
		else
			next_phase = phase + 2'h1;
		if (next_inFrame && next_slot == {1'b0, irqVector})
		begin
			if (next_phase == 2'h0 && irqPending)
			begin
				next_serirqOe = 1'b1;
				next_serirqOut = 1'b0;
			end
			else if (next_phase == 2'h1 && serirqOe && !serirqOut)
				next_serirqOe = 1'b1;
		end
	end

	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			inFrame <= 1'b0;
			lowRun <= 3'h0;
			slot <= 5'h00;
			phase <= 2'h0;
			serirqOut <= 1'b1;
			serirqOe <= 1'b0;
		end
		else
		begin
			inFrame <= next_inFrame;
			lowRun <= next_lowRun;
			slot <= next_slot;
			phase <= next_phase;
			serirqOut <= next_serirqOut;
			serirqOe <= next_serirqOe;
		end
	end
endmodule : lag_access_gate

// file: sim/lag_access_gate_asserts.sv
// concurrent checks on the ports of the access gate
`timescale 1ns/1ps
module lag_access_gate_asserts
(
	// clock and reset
	input wire logic clock,
	input wire logic reset,
	// lpc bus
	input wire logic [3:0] ladOut,
	input wire logic ladOe,
	input wire logic lframeN,
	// command engine side
	input wire logic [7:0] xferStatus,
	input wire logic [15:0] cycleAddr,
	input wire logic regWrite,
	input wire logic fifoPop,
	// state
	input wire logic [4:0] activeLocality,
	input wire logic lowPower
);
	import lag_pkg::*;
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	// ---------------------------------------------------------------
	// bus
	// ---------------------------------------------------------------
	AST_OE_START: assert property ($rose(ladOe) |->
		ladOut == SYNC_OK || ladOut == SYNC_LWAIT)
		else $error("drive began without a sync code");
	AST_FRAME_NO_DRIVE: assert property (!lframeN |=> !ladOe)
		else $error("device drove lad after frame low");
	AST_TURN_BACK: assert property ($fell(ladOe) |->
		$past(ladOut) == TAR_IDLE)
		else $error("release not preceded by turnaround");
	AST_WRITE_IN_SYNC: assert property (regWrite |->
		ladOe && ladOut == SYNC_OK)
		else $error("write passed out without sync ok");
	AST_POP_READY: assert property (fifoPop |->
		ladOe && ladOut == SYNC_OK && cycleAddr[11:0] == OFS_SHARED_FIFO
		&& $past(xferStatus[RESP_READY_BIT]))
		else $error("fifo pop without ready response");
	// ---------------------------------------------------------------
	// localities and power
	// ---------------------------------------------------------------
	AST_WAKE: assert property (lowPower && !lframeN |=> !lowPower)
		else $error("frame did not wake the device");
	AST_ONE_OWNER: assert property ($onehot0(activeLocality))
		else $error("more than one active locality");
	AST_DIGEST_GRANT: assert property (regWrite &&
		$past(activeLocality) == 5'h00 &&
		cycleAddr == {DIGEST_LOC, OFS_DIGEST_BEGIN} |->
		##[0:4] activeLocality == 5'h10)
		else $error("digest begin did not grant locality four");
	AST_DIGEST_FREE: assert property (regWrite &&
		cycleAddr == {DIGEST_LOC, OFS_DIGEST_FINISH} |->
		##[0:4] !activeLocality[4])
		else $error("digest finish did not release locality four");
	AST_RESET_STATE: assert property ($fell(reset) |->
		activeLocality == 5'h00 && lowPower && !ladOe)
		else $error("state not cleared by reset");
endmodule : lag_access_gate_asserts

bind lag_access_gate lag_access_gate_asserts chk (.clock(clock),
	.reset(reset), .ladOut(ladOut), .ladOe(ladOe), .lframeN(lframeN),
	.xferStatus(xferStatus), .cycleAddr(cycleAddr), .regWrite(regWrite),
	.fifoPop(fifoPop), .activeLocality(activeLocality),
	.lowPower(lowPower));

// file: sim/lag_host_model.sv
// lpc host controller model for the access gate
`timescale 1ns/1ps
module lag_host_model
	import lag_pkg::*;
(
	// clock
	input wire logic clock,
	// bus as driven by the device
	input wire logic [3:0] ladOut,
	input wire logic ladOe,
	// bus as seen by the device
	output logic [3:0] ladIn,
	output logic lframeN
);
	logic [3:0] hostLad;
	logic hostOe;
	logic [3:0] lastLad;
	int badSync;
	// released bus shows a changing level, never a stale copy
	assign ladIn = ladOe ? ladOut : (hostOe ? hostLad : ~lastLad);
	always @(posedge clock) lastLad <= ladIn;
	initial
	begin
		hostOe = 1'b1;
		hostLad = TAR_IDLE;
		lframeN = 1'b1;
		lastLad = 4'h0;
		badSync = 0;
	end
	task automatic put(input logic fr, input logic [3:0] v);
		@(negedge clock);
		lframeN = fr;
		hostOe = 1'b1;
		hostLad = v;
	endtask : put
	// nib below 4 breaks the cycle off after that many address nibbles
	task automatic xfer(input logic [3:0] st, input logic [3:0] ct,
		input logic [15:0] a, input logic [7:0] d, input int nib,
		output logic ok, output logic [7:0] rd);
		int n;
		ok = 1'b0;
		rd = 8'h00;
		put(1'b0, st);
		put(1'b1, ct);
		for (n = 3; n >= 4 - nib; n--)
			put(1'b1, a[n*4 +: 4]);
		if (nib < 4)
			return;
		if (ct[CTYPE_DIR_BIT])
		begin
			put(1'b1, d[3:0]);
			put(1'b1, d[7:4]);
		end
		put(1'b1, TAR_IDLE);
		@(negedge clock);
		hostOe = 1'b0;
		// no sync within the window is a master abort
		for (n = 0; n < 12 && !ok; n++)
		begin
			@(negedge clock);
			if (ladOe && ladOut === SYNC_OK)
				ok = 1'b1;
			else if (ladOe && ladOut !== SYNC_LWAIT)
				badSync++;
		end
		if (ok && !ct[CTYPE_DIR_BIT])
		begin
			@(negedge clock);
			rd[3:0] = ladIn;
			@(negedge clock);
			rd[7:4] = ladIn;
		end
		if (ok)
			repeat (2) @(negedge clock);
	endtask : xfer
endmodule : lag_host_model

// file: sim/tb.sv
// self-checking bench for the lpc locality access gate
`timescale 1ns/1ps
`define CHK(g, e) \
	begin \
		cmp_count++; \
		if ((g) !== (e)) \
		begin \
			fail_count++; \
			$display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); \
		end \
	end
module tb;
	import lag_pkg::*;
	localparam int IDLE = 50;
	localparam logic [3:0] RD = {CTYPE_TPM, 2'b00};
	localparam logic [3:0] WR = {CTYPE_TPM, 2'b10};
	logic clock, reset, lframeN, ladOe, serirqOut, serirqOe, serHost;
	logic [3:0] ladIn, ladOut;
	logic [7:0] xferStatus, fifoReadData, cfgReadData, intEvents, writeData;
	logic cmdDone, regWrite, fifoPop, lowPower, irqPending, ok, seen;
	logic [15:0] cycleAddr;
	logic [4:0] activeLocality;
	logic [7:0] rd;
	int fail_count = 0;
	int cmp_count = 0;
	int wrCount = 0;
	int popCount = 0;
	wire serirqLine = serirqOe ? serirqOut : serHost;
	lag_access_gate #(.IDLE_COUNT(IDLE), .WAKE_COUNT(8)) dut (.clock(clock),
		.reset(reset), .ladIn(ladIn), .ladOut(ladOut), .ladOe(ladOe),
		.lframeN(lframeN), .serirqIn(serirqLine), .serirqOut(serirqOut),
		.serirqOe(serirqOe), .xferStatus(xferStatus),
		.fifoReadData(fifoReadData), .cfgReadData(cfgReadData),
		.intEvents(intEvents), .cmdDone(cmdDone), .cycleAddr(cycleAddr),
		.writeData(writeData), .regWrite(regWrite), .fifoPop(fifoPop),
		.activeLocality(activeLocality), .lowPower(lowPower),
		.irqPending(irqPending));
	lag_host_model host (.clock(clock), .ladOut(ladOut), .ladOe(ladOe),
		.ladIn(ladIn), .lframeN(lframeN));
	initial
	begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	always @(posedge clock) if (regWrite === 1'b1) wrCount++;
	always @(posedge clock) if (fifoPop === 1'b1) popCount++;
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task automatic end_sim;
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_sim
	task automatic cyc(input logic [3:0] ct, input logic [15:0] a,
		input logic [7:0] d, input logic expOk);
		host.xfer(START_TPM, ct, a, d, 4, ok, rd);
		`CHK(ok, expOk)
	endtask : cyc
	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic s_none;
		`CHK(activeLocality, 5'h00)
		`CHK(lowPower, 1'b1)
		cyc(RD, {4'h0, OFS_ACCESS}, 8'h00, 1'b1);
		`CHK(rd[ACC_VALID_BIT], 1'b1)
		cyc(RD, {4'h0, OFS_XFER_STATUS}, 8'h00, 1'b0);
		cyc(WR, {4'h0, OFS_INT_ENABLE}, 8'h01, 1'b0);
		host.xfer(4'h0, RD, 16'h0000, 8'h00, 4, ok, rd);
		`CHK(ok, 1'b0)
		host.xfer(START_TPM, 4'h4, 16'h0000, 8'h00, 4, ok, rd);
		`CHK(ok, 1'b0)
		host.xfer(START_TPM, WR, {4'h0, OFS_ACCESS}, 8'h02, 2, ok, rd);
		cyc(RD, {4'h0, OFS_INT_ENABLE}, 8'h00, 1'b1);
		`CHK(activeLocality, 5'h00)
		`CHK(wrCount, 0)
	endtask : s_none
	task automatic s_digest;
		cyc(WR, {DIGEST_LOC, OFS_DIGEST_BEGIN}, 8'h00, 1'b1);
		`CHK(activeLocality, 5'h10)
		cyc(WR, {DIGEST_LOC, OFS_DIGEST_BEGIN}, 8'h00, 1'b1);
		`CHK(activeLocality, 5'h10)
		cyc(WR, {DIGEST_LOC, OFS_SHARED_FIFO}, 8'h5a, 1'b1);
		`CHK(writeData, 8'h5a)
		cyc(WR, {DIGEST_LOC, OFS_DIGEST_FINISH}, 8'h00, 1'b1);
		`CHK(activeLocality, 5'h00)
	endtask : s_digest
	task automatic s_grant;
		cyc(WR, {4'h0, OFS_ACCESS}, 8'h02, 1'b1);
		`CHK(activeLocality, 5'h01)
		cyc(RD, {4'h1, OFS_ACCESS}, 8'h00, 1'b1);
		`CHK(rd[ACC_ACTIVE_BIT], 1'b0)
		cyc(WR, {4'h0, OFS_INT_ENABLE}, 8'h01, 1'b1);
		cyc(WR, {4'h1, OFS_INT_ENABLE}, 8'hfe, 1'b0);
		cyc(RD, {4'h1, OFS_INT_ENABLE}, 8'h00, 1'b1);
		cyc(RD, {4'h0, OFS_INT_ENABLE}, 8'h00, 1'b1);
		`CHK(rd, 8'h01)
		cyc(RD, {4'h1, OFS_XFER_STATUS}, 8'h00, 1'b0);
		cyc(RD, {4'h1, OFS_SHARED_FIFO}, 8'h00, 1'b0);
		cyc(WR, {4'h1, 12'hf00}, 8'h00, 1'b0);
		cyc(WR, {DIGEST_LOC, OFS_DIGEST_BEGIN}, 8'h00, 1'b0);
		cyc(WR, {4'h0, OFS_INT_CAP}, 8'h00, 1'b0);
		cyc(RD, {4'h0, OFS_INT_CAP}, 8'h00, 1'b1);
		`CHK(rd, INT_CAP_VALUE)
		cyc(RD, {4'h0, 12'hf00}, 8'h00, 1'b1);
		`CHK(rd, 8'h3c)
		`CHK(wrCount, 6)
	endtask : s_grant
	task automatic s_fifo;
		cyc(RD, {4'h0, OFS_SHARED_FIFO}, 8'h00, 1'b0);
		cyc(WR, {4'h0, OFS_SHARED_FIFO}, 8'hc3, 1'b1);
		`CHK(writeData, 8'hc3)
		xferStatus = 8'h10;
		cyc(RD, {4'h0, OFS_XFER_STATUS}, 8'h00, 1'b1);
		`CHK(rd, 8'h10)
		cyc(RD, {4'h0, OFS_SHARED_FIFO}, 8'h00, 1'b1);
		`CHK(rd, 8'ha5)
		`CHK(popCount, 1)
	endtask : s_fifo
	task automatic s_irq;
		intEvents = 8'h01;
		@(negedge clock);
		intEvents = 8'h00;
		repeat (3) @(negedge clock);
		`CHK(irqPending, 1'b1)
		serHost = 1'b0;
		repeat (5) @(negedge clock);
		serHost = 1'b1;
		seen = 1'b0;
		repeat (12)
		begin
			@(negedge clock);
			if (serirqOe === 1'b1 && serirqOut === 1'b0)
				seen = 1'b1;
		end
		`CHK(seen, 1'b1)
		cyc(WR, {4'h0, OFS_INT_STATUS}, 8'h01, 1'b1);
		repeat (2) @(negedge clock);
		`CHK(irqPending, 1'b0)
	endtask : s_irq
	task automatic s_power;
		// let the idle timer run out so the wake below is known
		repeat (IDLE + 2) @(negedge clock);
		`CHK(lowPower, 1'b1)
		cyc(RD, {4'h0, OFS_ACCESS}, 8'h00, 1'b1);
		cmdDone = 1'b1;
		@(negedge clock);
		cmdDone = 1'b0;
		repeat (IDLE - 10) @(negedge clock);
		`CHK(lowPower, 1'b0)
		repeat (20) @(negedge clock);
		`CHK(lowPower, 1'b1)
		cyc(RD, {4'h0, OFS_ACCESS}, 8'h00, 1'b1);
		`CHK(lowPower, 1'b0)
	endtask : s_power
	task automatic s_reset_mid;
		host.xfer(START_TPM, WR, {4'h0, OFS_ACCESS}, 8'h00, 2, ok, rd);
		reset = 1'b1;
		@(negedge clock);
		reset = 1'b0;
		`CHK(activeLocality, 5'h00)
		`CHK(ladOe, 1'b0)
		cyc(RD, {4'h0, OFS_ACCESS}, 8'h00, 1'b1);
	endtask : s_reset_mid
	// ---------------------------------------------------------------
	// main sequence and watchdog
	// ---------------------------------------------------------------
	initial
	begin
		reset = 1'b1;
		xferStatus = 8'h00;
		fifoReadData = 8'ha5;
		cfgReadData = 8'h3c;
		intEvents = 8'h00;
		cmdDone = 1'b0;
		serHost = 1'b1;
		repeat (4) @(negedge clock);
		reset = 1'b0;
		s_none;
		s_digest;
		s_grant;
		s_fifo;
		s_irq;
		s_power;
		s_reset_mid;
		`CHK(host.badSync, 0)
		end_sim;
	end
	// whole run is under a thousand cycles; allow twenty times that
	initial
	begin
		#80000;
		fail_count++;
		end_sim;
	end
endmodule : tb
